// ===== hw/rcs_pkg.sv
/*
 * Shared constants for the reset cause and start-up time-out block:
 * register indices and byte addresses, field positions, reset values,
 * oscillator select codes and time-out counts.
 * Assumes a 50 MHz block clock and a 32-bit AXI4-Lite register bus.
 */
package rcs_pkg;

  // Register indices; byte address is four times the index
  localparam int IDX_STATUS = 'h03;
  localparam int IDX_POWER_CONTROL = 'h8e;
  localparam int IDX_CONFIG = 'h90;
  localparam int IDX_EV_STATUS = 'ha0;
  localparam int IDX_EV_CLEAR = 'ha1;
  localparam int IDX_EV_ENABLE = 'ha2;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(4 * IDX_STATUS);
  localparam logic [ADDR_W-1:0] ADDR_POWER_CONTROL = ADDR_W'(4 * IDX_POWER_CONTROL);
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = ADDR_W'(4 * IDX_CONFIG);
  localparam logic [ADDR_W-1:0] ADDR_EV_STATUS = ADDR_W'(4 * IDX_EV_STATUS);
  localparam logic [ADDR_W-1:0] ADDR_EV_CLEAR = ADDR_W'(4 * IDX_EV_CLEAR);
  localparam logic [ADDR_W-1:0] ADDR_EV_ENABLE = ADDR_W'(4 * IDX_EV_ENABLE);

  // Processor status fields
  localparam int ST_BANK_LSB = 5;
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  // Power control fields
  localparam int PC_ULP = 5;
  localparam int PC_SW_BROWNOUT_ENABLE = 4;
  localparam int PC_WUR = 3;
  localparam int PC_POR = 1;
  localparam int PC_BOR = 0;
  // Configuration word fields
  localparam int CF_BOR_MODE_LSB = 8;
  localparam int CF_DATA_PROT = 7;
  localparam int CF_CODE_PROT = 6;
  localparam int CF_EXT_PIN_EN = 5;
  localparam int CF_PWRT_EN_N = 4;
  localparam int CF_WDT_EN = 3;
  localparam int CF_OSC_LSB = 0;

  // Power-on values; unknown bits taken as shown
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [7:0] POWER_CONTROL_POR = 8'h19;

  // Brown-out mode select
  localparam logic [1:0] BOR_OFF = 2'h0;
  localparam logic [1:0] BOR_SW = 2'h1;
  localparam logic [1:0] BOR_AWAKE = 2'h2;

  // Oscillator select codes of the crystal modes
  localparam logic [2:0] OSC_CRYSTAL_LOW = 3'h0;
  localparam logic [2:0] OSC_CRYSTAL_STD = 3'h1;
  localparam logic [2:0] OSC_CRYSTAL_FAST = 3'h2;

  // Cause event bits
  localparam int EV_POR = 0;
  localparam int EV_BOR = 1;
  localparam int EV_WDT_RST = 2;
  localparam int EV_WDT_WAKE = 3;
  localparam int EV_EXT = 4;
  localparam int EV_EXT_SLEEP = 5;
  localparam int EV_WAKE = 6;
  localparam int EV_STARTED = 7;

  // Time-outs
  localparam int CLK_FREQ_KHZ = 50000;
  localparam int PWRT_TIME_MS = 64;
  localparam int PWRT_CYCLES = PWRT_TIME_MS * CLK_FREQ_KHZ;
  localparam int OST_CYCLES = 1024;
  localparam int CNT_W = 24;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RCS_IDLE,
    RCS_HOLD,
    RCS_PWRT,
    RCS_OST
  } rcs_seq_t;

endpackage : rcs_pkg

// ===== hw/rcs_count.sv
/*
 * Down counter for one start-up time-out phase.
 * Assumes load_val is at least one; a load restarts the count at once.
 */
`timescale 1ns/1ps
`default_nettype none
module rcs_count #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } rcs_count_state_t;

  rcs_count_state_t q_reg, q_next;

  always_comb begin
    q_next = q_reg;
    q_next.done = 1'b0;
    if (load) begin
      q_next.cnt = load_val;
      q_next.busy = 1'b1;
    end else if (q_reg.busy) begin
      q_next.cnt = q_reg.cnt - W'(1);
      if (q_reg.cnt == W'(1)) begin
        q_next.busy = 1'b0;
        q_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign done = q_reg.done;

endmodule : rcs_count
`default_nettype wire

// ===== hw/rcs_top.sv
/*
 * Reset cause recorder and start-up time-out sequencer, with an
 * AXI4-Lite register slave and a cause-event interrupt.
 * Assumes reset requests arrive asynchronously as levels from the
 * reset circuits, and sleep_cmd/clrwdt_cmd are one-cycle pulses from
 * core logic on clk. The configuration word is a static input.
 */
`timescale 1ns/1ps
`default_nettype none
module rcs_top #(
  parameter int PWRT_CYCLES = rcs_pkg::PWRT_CYCLES,
  parameter int OST_CYCLES = rcs_pkg::OST_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic por_req,
  input wire logic bor_req,
  input wire logic wdt_req,
  input wire logic ext_reset_pin_req,
  input wire logic wake_reset_req,
  input wire logic sleep_cmd,
  input wire logic clrwdt_cmd,
  input wire logic [9:0] device_configuration_word,
  output logic core_reset_hold,
  output logic irq,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Request order: power-on, brown-out, watchdog, pin, wake
  localparam int NREQ = 5;
  localparam int RQ_POR = 0;
  localparam int RQ_BOR = 1;
  localparam int RQ_WDT = 2;
  localparam int RQ_EXT = 3;
  localparam int RQ_WAKE = 4;

  typedef struct packed {
    logic [NREQ-1:0] sync1;
    logic [NREQ-1:0] sync2;
    logic [NREQ-1:0] prev;
    rcs_pkg::rcs_seq_t seq;
    logic seq_powerup;
    logic seq_wake;
    logic asleep;
    logic [7:0] processor_status;
    logic [7:0] power_control;
    logic [7:0] ev_status;
    logic [7:0] ev_enable;
    logic aw_have;
    logic [11:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rcs_top_state_t;

  rcs_top_state_t q_reg, q_next;
  logic cnt_load;
  logic [rcs_pkg::CNT_W-1:0] cnt_val;
  logic cnt_done;

  rcs_count #(
    .W(rcs_pkg::CNT_W)
  ) u_count (
    .clk(clk),
    .rst(rst),
    .load(cnt_load),
    .load_val(cnt_val),
    .done(cnt_done)
  );

  logic [1:0] bor_mode;
  logic crystal;
  logic pwrt_en;
  logic bor_enabled;
  logic [NREQ-1:0] req_live;
  logic [NREQ-1:0] req_edge;
  logic [7:0] ev_set;
  logic wr_go;
  logic [31:0] rd_word;
  logic rd_ok;

  always_comb begin
    bor_mode = device_configuration_word[rcs_pkg::CF_BOR_MODE_LSB +: 2];
    crystal = (device_configuration_word[rcs_pkg::CF_OSC_LSB +: 3] == rcs_pkg::OSC_CRYSTAL_LOW)
      || (device_configuration_word[rcs_pkg::CF_OSC_LSB +: 3] == rcs_pkg::OSC_CRYSTAL_STD)
      || (device_configuration_word[rcs_pkg::CF_OSC_LSB +: 3] == rcs_pkg::OSC_CRYSTAL_FAST);
    pwrt_en = !device_configuration_word[rcs_pkg::CF_PWRT_EN_N];
    // Detection off in mode 00, so brown-out requests are ignored there
    if (bor_mode == rcs_pkg::BOR_OFF) begin
      bor_enabled = 1'b0;
    end else if (bor_mode == rcs_pkg::BOR_SW) begin
      bor_enabled = q_reg.power_control[rcs_pkg::PC_SW_BROWNOUT_ENABLE];
    end else if (bor_mode == rcs_pkg::BOR_AWAKE) begin
      bor_enabled = !q_reg.asleep;
    end else begin
      bor_enabled = 1'b1;
    end
    req_live = q_reg.sync2;
    req_live[RQ_BOR] = q_reg.sync2[RQ_BOR] && bor_enabled;
    req_live[RQ_EXT] = q_reg.sync2[RQ_EXT]
      && device_configuration_word[rcs_pkg::CF_EXT_PIN_EN];
    req_edge = req_live & ~q_reg.prev;
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = '0;
    if (s_axi_araddr == rcs_pkg::ADDR_STATUS) begin
      rd_word = {24'h000000, q_reg.processor_status};
    end else if (s_axi_araddr == rcs_pkg::ADDR_POWER_CONTROL) begin
      rd_word = {24'h000000, q_reg.power_control};
    end else if (s_axi_araddr == rcs_pkg::ADDR_CONFIG) begin
      rd_word = {22'h0, device_configuration_word};
    end else if (s_axi_araddr == rcs_pkg::ADDR_EV_STATUS) begin
      rd_word = {24'h000000, q_reg.ev_status};
    end else if (s_axi_araddr == rcs_pkg::ADDR_EV_ENABLE) begin
      rd_word = {24'h000000, q_reg.ev_enable};
    end else if (s_axi_araddr == rcs_pkg::ADDR_EV_CLEAR) begin
      rd_word = '0;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    q_next = q_reg;
    q_next.sync1 = {wake_reset_req, ext_reset_pin_req, wdt_req, bor_req, por_req};
    q_next.sync2 = q_reg.sync1;
    q_next.prev = req_live;
    ev_set = '0;
    cnt_load = 1'b0;
    cnt_val = '0;
    wr_go = q_reg.aw_have && q_reg.w_have;

    // Bus write; hardware events below override in the same cycle
    if (s_axi_awvalid && s_axi_awready) begin
      q_next.aw_have = 1'b1;
      q_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      q_next.w_have = 1'b1;
      q_next.w_data = s_axi_wdata[7:0];
      q_next.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      q_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      q_next.aw_have = 1'b0;
      q_next.w_have = 1'b0;
      q_next.bvalid = 1'b1;
      q_next.bresp = rcs_pkg::RESP_OKAY;
      if (q_reg.aw_addr == rcs_pkg::ADDR_STATUS) begin
        // Timeout and power-down flags are not software writable
        if (q_reg.w_lane0) begin
          q_next.processor_status[7:5] = q_reg.w_data[7:5];
          q_next.processor_status[2:0] = q_reg.w_data[2:0];
        end
      end else if (q_reg.aw_addr == rcs_pkg::ADDR_POWER_CONTROL) begin
        if (q_reg.w_lane0) begin
          q_next.power_control = q_reg.w_data & 8'h3b;
        end
      end else if (q_reg.aw_addr == rcs_pkg::ADDR_EV_CLEAR) begin
        if (q_reg.w_lane0) begin
          q_next.ev_status = q_reg.ev_status & ~q_reg.w_data;
        end
      end else if (q_reg.aw_addr == rcs_pkg::ADDR_EV_ENABLE) begin
        if (q_reg.w_lane0) begin
          q_next.ev_enable = q_reg.w_data;
        end
      end else if (q_reg.aw_addr == rcs_pkg::ADDR_STATUS || q_reg.aw_addr == rcs_pkg::ADDR_CONFIG
          || q_reg.aw_addr == rcs_pkg::ADDR_EV_STATUS) begin
        q_next.bresp = rcs_pkg::RESP_OKAY;
      end else begin
        q_next.bresp = rcs_pkg::RESP_SLVERR;
      end
    end

    // Bus read
    if (s_axi_rvalid && s_axi_rready) begin
      q_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      q_next.rvalid = 1'b1;
      q_next.rdata = rd_word;
      q_next.rresp = rd_ok ? rcs_pkg::RESP_OKAY : rcs_pkg::RESP_SLVERR;
    end

    // Core instructions that touch the flags
    if (sleep_cmd) begin
      q_next.asleep = 1'b1;
      q_next.processor_status[rcs_pkg::ST_TO] = 1'b1;
      q_next.processor_status[rcs_pkg::ST_PD] = 1'b0;
    end else if (clrwdt_cmd) begin
      q_next.processor_status[rcs_pkg::ST_TO] = 1'b1;
      q_next.processor_status[rcs_pkg::ST_PD] = 1'b1;
    end

    // Cause flags load on the request edge, long before release
    if (req_edge[RQ_POR]) begin
      q_next.processor_status = rcs_pkg::STATUS_POR;
      q_next.power_control[rcs_pkg::PC_ULP] = 1'b0;
      q_next.power_control[rcs_pkg::PC_SW_BROWNOUT_ENABLE] = 1'b1;
      q_next.power_control[rcs_pkg::PC_WUR] = 1'b1;
      q_next.power_control[rcs_pkg::PC_POR] = 1'b0;
      ev_set[rcs_pkg::EV_POR] = 1'b1;
    end else if (req_edge[RQ_BOR]) begin
      q_next.processor_status[7:5] = 3'h0;
      q_next.processor_status[rcs_pkg::ST_TO] = 1'b1;
      q_next.processor_status[rcs_pkg::ST_PD] = 1'b1;
      q_next.power_control[rcs_pkg::PC_ULP] = 1'b0;
      q_next.power_control[rcs_pkg::PC_BOR] = 1'b0;
      ev_set[rcs_pkg::EV_BOR] = 1'b1;
    end else if (req_edge[RQ_WAKE]) begin
      q_next.processor_status[7:5] = 3'h0;
      q_next.processor_status[rcs_pkg::ST_TO] = 1'b1;
      q_next.processor_status[rcs_pkg::ST_PD] = 1'b0;
      q_next.power_control[rcs_pkg::PC_ULP] = 1'b0;
      q_next.power_control[rcs_pkg::PC_WUR] = 1'b0;
      ev_set[rcs_pkg::EV_WAKE] = 1'b1;
    end else if (req_edge[RQ_EXT]) begin
      q_next.processor_status[7:5] = 3'h0;
      q_next.power_control[rcs_pkg::PC_ULP] = 1'b0;
      if (q_reg.asleep) begin
        q_next.processor_status[rcs_pkg::ST_TO] = 1'b1;
        q_next.processor_status[rcs_pkg::ST_PD] = 1'b0;
        ev_set[rcs_pkg::EV_EXT_SLEEP] = 1'b1;
      end else begin
        ev_set[rcs_pkg::EV_EXT] = 1'b1;
      end
    end else if (req_edge[RQ_WDT]) begin
      q_next.processor_status[rcs_pkg::ST_TO] = 1'b0;
      if (q_reg.asleep) begin
        // A wake resumes execution: bank bits and power control kept
        q_next.processor_status[rcs_pkg::ST_PD] = 1'b0;
        ev_set[rcs_pkg::EV_WDT_WAKE] = 1'b1;
      end else begin
        q_next.processor_status[7:5] = 3'h0;
        q_next.power_control[rcs_pkg::PC_ULP] = 1'b0;
        ev_set[rcs_pkg::EV_WDT_RST] = 1'b1;
      end
    end

    // Start-up sequence
    if (|req_live) begin
      // A request during the delay re-initialises it
      q_next.seq = rcs_pkg::RCS_HOLD;
      if (|req_edge) begin
        q_next.asleep = 1'b0;
        q_next.seq_powerup = (req_edge[RQ_POR] || req_edge[RQ_BOR])
          || (q_reg.seq == rcs_pkg::RCS_HOLD && q_reg.seq_powerup);
        q_next.seq_wake = req_edge[RQ_WAKE] || (req_edge[RQ_WDT] && q_reg.asleep)
          || (req_edge[RQ_EXT] && q_reg.asleep);
      end
    end else begin
      case (q_reg.seq)
        rcs_pkg::RCS_HOLD: begin
          if (q_reg.seq_powerup && pwrt_en) begin
            q_next.seq = rcs_pkg::RCS_PWRT;
            cnt_load = 1'b1;
            cnt_val = rcs_pkg::CNT_W'(PWRT_CYCLES);
          end else if (crystal && (q_reg.seq_powerup || q_reg.seq_wake)) begin
            q_next.seq = rcs_pkg::RCS_OST;
            cnt_load = 1'b1;
            cnt_val = rcs_pkg::CNT_W'(OST_CYCLES);
          end else begin
            q_next.seq = rcs_pkg::RCS_IDLE;
            ev_set[rcs_pkg::EV_STARTED] = 1'b1;
          end
        end
        rcs_pkg::RCS_PWRT: begin
          if (cnt_done) begin
            if (crystal) begin
              q_next.seq = rcs_pkg::RCS_OST;
              cnt_load = 1'b1;
              cnt_val = rcs_pkg::CNT_W'(OST_CYCLES);
            end else begin
              q_next.seq = rcs_pkg::RCS_IDLE;
              ev_set[rcs_pkg::EV_STARTED] = 1'b1;
            end
          end
        end
        rcs_pkg::RCS_OST: begin
          if (cnt_done) begin
            q_next.seq = rcs_pkg::RCS_IDLE;
            ev_set[rcs_pkg::EV_STARTED] = 1'b1;
          end
        end
        default: begin
          q_next.seq = rcs_pkg::RCS_IDLE;
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    q_next.ev_status = q_next.ev_status | ev_set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= '0;
      q_reg.seq <= rcs_pkg::RCS_HOLD;
      q_reg.seq_powerup <= 1'b1;
      q_reg.processor_status <= rcs_pkg::STATUS_POR;
      q_reg.power_control <= rcs_pkg::POWER_CONTROL_POR;
    end else begin
      q_reg <= q_next;
    end
  end

  assign core_reset_hold = (q_reg.seq != rcs_pkg::RCS_IDLE);
  assign irq = |(q_reg.ev_status & q_reg.ev_enable);
  assign s_axi_awready = !q_reg.aw_have && !q_reg.bvalid;
  assign s_axi_wready = !q_reg.w_have && !q_reg.bvalid;
  assign s_axi_bvalid = q_reg.bvalid;
  assign s_axi_bresp = q_reg.bresp;
  assign s_axi_arready = !q_reg.rvalid;
  assign s_axi_rvalid = q_reg.rvalid;
  assign s_axi_rdata = q_reg.rdata;
  assign s_axi_rresp = q_reg.rresp;

endmodule : rcs_top
`default_nettype wire

// ===== dv/rcs_chk.sv
/*
 * Port-level checker for rcs_top: bus answers, reset hold and time-out length.
 * Assumes one clock, synchronous active-high rst, and the bind below.
 */
`timescale 1ns/1ps
`default_nettype none
module rcs_chk #(
  parameter int PWRT_CYCLES = 40,
  parameter int OST_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic por_req,
  input wire logic bor_req,
  input wire logic wdt_req,
  input wire logic ext_reset_pin_req,
  input wire logic wake_reset_req,
  input wire logic sleep_cmd,
  input wire logic [9:0] device_configuration_word,
  input wire logic core_reset_hold,
  input wire logic irq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  int since_reg;
  int need_reg;
  logic asleep_reg;
  logic any_req;
  int osc_need;
  int pu_need;
  assign any_req = rst | por_req | bor_req | wdt_req | ext_reset_pin_req | wake_reset_req;
  assign osc_need = (device_configuration_word[2:0] <= rcs_pkg::OSC_CRYSTAL_FAST) ? OST_CYCLES : 0;
  assign pu_need = (device_configuration_word[4] ? 0 : PWRT_CYCLES) + osc_need;
  // Required hold is fixed at the request edge, before sleep is forgotten
  always_ff @(posedge clk) begin
    since_reg <= any_req ? 0 : ((since_reg < 60000) ? since_reg + 1 : since_reg);
    if (rst || core_reset_hold) asleep_reg <= 1'b0;
    else if (sleep_cmd) asleep_reg <= 1'b1;
    if (rst || $rose(por_req) || $rose(bor_req)) need_reg <= pu_need;
    else if ($rose(wake_reset_req)) need_reg <= osc_need;
    else if ($rose(wdt_req) || $rose(ext_reset_pin_req)) need_reg <= asleep_reg ? osc_need : 0;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_bresp_due;
    ##[1:2] s_axi_bvalid;
  endsequence
  chk_write_answer: assert property (s_wr_taken |-> s_bresp_due)
    else $error("write answer late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_hold_on_req: assert property ($rose(por_req) || $rose(wake_reset_req) |-> ##[1:4] core_reset_hold)
    else $error("reset request not held");
  chk_hold_after_rst: assert property ($fell(rst) |-> core_reset_hold && !irq)
    else $error("hold or irq wrong after reset");
  chk_hold_min: assert property ($fell(core_reset_hold) |-> since_reg >= need_reg)
    else $error("time-out too short");
  chk_hold_max: assert property ($fell(core_reset_hold) |-> since_reg <= need_reg + 10)
    else $error("time-out too long");
endmodule : rcs_chk
bind rcs_top rcs_chk #(.PWRT_CYCLES(PWRT_CYCLES), .OST_CYCLES(OST_CYCLES)) u_rcs_chk (.clk, .rst,
  .por_req, .bor_req, .wdt_req, .ext_reset_pin_req, .wake_reset_req, .sleep_cmd,
  .device_configuration_word, .core_reset_hold, .irq, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ===== dv/rcs_top_tb.sv
/*
 * Self-checking bench for rcs_top: reset causes, flags, time-outs, events.
 * Assumes short time-out parameters and the AXI4-Lite timing of rcs_top.
 */
`timescale 1ns/1ps
`default_nettype none
module rcs_top_tb;
  localparam int PW = 40;
  localparam int OS = 8;
  logic clk, rst, sleep_cmd, clrwdt_cmd, core_reset_hold, irq;
  logic [4:0] rq_v;
  logic [9:0] device_configuration_word;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int mismatches, check_count, st, pc, ev, len, need, osc, r;
  bit asleep;
  // Per step: sleep first, cause (0 por,1 bor,2 wdt,3 pin,4 wake), configuration
  int sl_t[10] = '{0, 0, 1, 1, 1, 0, 1, 0, 0, 0};
  int kd_t[10] = '{3, 2, 2, 3, 4, 1, 1, 0, 0, 1};
  int cf_t[10] = '{'h329, 'h329, 'h329, 'h329, 'h329, 'h328, 'h32a, 'h329, 'h33d, 'h32d};
  rcs_top #(.PWRT_CYCLES(PW), .OST_CYCLES(OS)) u_rcs_top (.clk, .rst, .por_req(rq_v[0]),
    .bor_req(rq_v[1]), .wdt_req(rq_v[2]), .ext_reset_pin_req(rq_v[3]), .wake_reset_req(rq_v[4]),
    .sleep_cmd, .clrwdt_cmd, .device_configuration_word, .core_reset_hold, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bit ap, wp;
    ap = 1;
    wp = 1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (ap || wp) begin
      @(posedge clk);
      if (ap && s_axi_awready) begin
        ap = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready) begin
        wp = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Late bready lets the answer stand for a while
    repeat (2) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd
  task automatic hold_len();
    len = 0;
    do begin
      @(posedge clk);
      len++;
    end while (core_reset_hold === 1'b1);
  endtask : hold_len
  task automatic fire(input int k);
    @(posedge clk);
    rq_v[k] <= 1'b1;
    repeat (4) @(posedge clk);
    rq_v <= 5'h0;
    cmp("hold_raised", 32'h1, {31'h0, core_reset_hold});
    hold_len();
  endtask : fire
  task automatic model(input int k, input int cf);
    osc = ((cf & 7) <= 2) ? OS : 0;
    need = (((cf >> 4) & 1) ? 0 : PW) + osc;
    case (k)
      0: begin
        st = 8'h18;
        // Brown-out flag is unknown after power-on; the design keeps it
        pc = 8'h18 | (pc & 8'h01);
        ev = 8'h01;
      end
      1: begin
        st = (st & 8'h07) | 8'h18;
        pc = pc & 8'h1a;
        ev = 8'h02;
      end
      2: begin
        st = asleep ? st & 8'h07 : st & 8'h0f;
        // Wake enable bit clears on a watchdog reset, not on a wake
        pc = asleep ? pc : pc & 8'h1f;
        ev = asleep ? 8'h08 : 8'h04;
        need = asleep ? osc : 0;
      end
      3: begin
        st = asleep ? (st & 8'h07) | 8'h10 : st;
        pc = pc & 8'h1f;
        ev = asleep ? 8'h20 : 8'h10;
        need = asleep ? osc : 0;
      end
      default: begin
        st = (st & 8'h07) | 8'h10;
        pc = pc & 8'h17;
        ev = 8'h40;
        need = osc;
      end
    endcase
    asleep = 0;
  endtask : model
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  initial begin
    {rst, rq_v, sleep_cmd, clrwdt_cmd, s_axi_awvalid, s_axi_wvalid} = 10'h200;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 27'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    device_configuration_word = 10'h329;
    asleep = 0;
    r = $urandom(32'hfd10);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    hold_len();
    cmp("powerup_len", 32'h1, {31'h0, len >= PW + OS && len <= PW + OS + 10});
    rd(rcs_pkg::ADDR_STATUS);
    cmp("status", 32'h18, d);
    rd(rcs_pkg::ADDR_POWER_CONTROL);
    cmp("power_control", 32'h19, d);
    rd(rcs_pkg::ADDR_EV_STATUS);
    cmp("events", 32'h80, d);
    cmp("irq", 32'h0, {31'h0, irq});
    st = 8'h18;
    r = $urandom;
    wr(rcs_pkg::ADDR_STATUS, r & 32'hffffff07);
    st = st | (r & 7);
    rd(rcs_pkg::ADDR_STATUS);
    cmp("status_wr", st, d);
    wr(rcs_pkg::ADDR_CONFIG, 32'h0);
    cmp("ro_resp", rcs_pkg::RESP_OKAY, resp);
    rd(rcs_pkg::ADDR_CONFIG);
    cmp("config", 32'h329, d);
    rd(12'h100);
    cmp("unmapped_rd", {30'h0, rcs_pkg::RESP_SLVERR}, {d[29:0], resp});
    wr(12'h100, 32'h0);
    cmp("unmapped_wr", rcs_pkg::RESP_SLVERR, resp);
    for (int i = 0; i < 10; i++) begin
      device_configuration_word <= cf_t[i][9:0];
      clrwdt_cmd <= 1'b1;
      @(posedge clk);
      clrwdt_cmd <= 1'b0;
      st = st | 8'h18;
      r = $urandom;
      // Flag bits written as one, as software must after a power-on
      wr(rcs_pkg::ADDR_POWER_CONTROL, r | 32'h3);
      pc = (r | 3) & 8'h3b;
      if (sl_t[i] != 0) begin
        @(posedge clk);
        sleep_cmd <= 1'b1;
        @(posedge clk);
        sleep_cmd <= 1'b0;
        st = (st & 8'hf7) | 8'h10;
        asleep = 1;
      end
      rd(rcs_pkg::ADDR_STATUS);
      cmp("status_pre", st, d);
      fire(kd_t[i]);
      model(kd_t[i], cf_t[i]);
      cmp("hold_len", 32'h1, {31'h0, len >= need && len <= need + 10});
      rd(rcs_pkg::ADDR_STATUS);
      cmp("status_cause", st & 8'hf8, d & 32'hf8);
      rd(rcs_pkg::ADDR_POWER_CONTROL);
      cmp("power_control_cause", pc, d);
      rd(rcs_pkg::ADDR_EV_STATUS);
      cmp("event_cause", ev, d & 32'h7f);
      wr(rcs_pkg::ADDR_EV_ENABLE, 32'h7f & ~ev);
      cmp("irq_masked", 32'h0, {31'h0, irq});
      wr(rcs_pkg::ADDR_EV_ENABLE, 32'h7f);
      cmp("irq_on", 32'h1, {31'h0, irq});
      wr(rcs_pkg::ADDR_EV_CLEAR, 32'hff);
      rd(rcs_pkg::ADDR_EV_STATUS);
      cmp("event_clr", 32'h0, d);
      cmp("irq_off", 32'h0, {31'h0, irq});
    end
    // Brown-out detection off: the request must change nothing
    device_configuration_word <= 10'h029;
    @(posedge clk);
    rq_v[1] <= 1'b1;
    repeat (6) @(posedge clk);
    cmp("bor_off_hold", 32'h0, {31'h0, core_reset_hold});
    rq_v <= 5'h0;
    rd(rcs_pkg::ADDR_POWER_CONTROL);
    cmp("bor_off_power_control", pc, d);
    wrap_up();
  end
endmodule : rcs_top_tb
`default_nettype wire
